// *** sim/bdf_asserts.sv ***
// port flag and bus-drive properties of the bidirectional buffer
`timescale 1ns/1ps
`default_nettype none
module bdf_asserts (
	// system
	input wire logic sys_clk,
	input wire logic rst,
	// port pins
	input wire logic port_a_clock,
	input wire logic port_b_clock,
	input wire logic port_a_select_n,
	input wire logic port_a_write,
	input wire logic port_a_mail_select,
	input wire logic port_a_data_oe_n,
	// flags
	input wire logic port_a_full_n,
	input wire logic port_b_full_n,
	input wire logic port_a_empty_n,
	input wire logic port_b_empty_n,
	input wire logic port_a_almost_empty_n,
	input wire logic port_b_almost_empty_n,
	input wire logic mail_to_b_flag_n
);
	logic [3:0] a_age, b_age;
	logic       a_prev, b_prev;
	// system cycles since each port clock pin last rose
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			a_prev <= 1'b0;
			b_prev <= 1'b0;
			a_age <= 4'hf;
			b_age <= 4'hf;
		end else begin
			a_prev <= port_a_clock;
			b_prev <= port_b_clock;
			a_age <= (port_a_clock && !a_prev) ? 4'h0 : a_age + {3'h0, a_age != 4'hf};
			b_age <= (port_b_clock && !b_prev) ? 4'h0 : b_age + {3'h0, b_age != 4'hf};
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_reset_flags;
		disable iff (1'b0) rst && $past(rst) |-> !port_a_full_n && !port_b_full_n
			&& !port_a_empty_n && !port_b_empty_n && mail_to_b_flag_n;
	endproperty
	property p_a_sync;
		$changed({port_a_full_n, port_a_empty_n, port_a_almost_empty_n}) |-> a_age <= 4'h6;
	endproperty
	property p_b_sync;
		$changed({port_b_full_n, port_b_empty_n, port_b_almost_empty_n}) |-> b_age <= 4'h6;
	endproperty
	property p_a_ae;
		!port_a_empty_n |-> !port_a_almost_empty_n;
	endproperty
	property p_b_ae;
		!port_b_empty_n |-> !port_b_almost_empty_n;
	endproperty
	property p_oe_idle;
		port_a_select_n [*5] |-> port_a_data_oe_n;
	endproperty
	property p_oe_read;
		(!port_a_select_n && !port_a_write) [*5] |-> !port_a_data_oe_n;
	endproperty
	property p_mail_fall;
		$fell(mail_to_b_flag_n) |-> a_age <= 4'h6 && $past(port_a_mail_select, 3);
	endproperty
	property p_mail_rise;
		$rose(mail_to_b_flag_n) |-> b_age <= 4'h6;
	endproperty
	a_reset_flags: assert property (p_reset_flags) else $error("flag wrong in reset");
	a_a_sync: assert property (p_a_sync) else $error("port a flag moved off edge");
	a_b_sync: assert property (p_b_sync) else $error("port b flag moved off edge");
	a_a_ae: assert property (p_a_ae) else $error("port a almost empty high");
	a_b_ae: assert property (p_b_ae) else $error("port b almost empty high");
	a_oe_idle: assert property (p_oe_idle) else $error("bus driven while idle");
	a_oe_read: assert property (p_oe_read) else $error("bus not driven on read");
	a_mail_fall: assert property (p_mail_fall) else $error("mail flag fell unasked");
	a_mail_rise: assert property (p_mail_rise) else $error("mail flag rose unasked");
	c_full: cover property ($fell(port_a_full_n));
	c_mail: cover property ($fell(mail_to_b_flag_n));
	c_data: cover property ($rose(port_b_empty_n));
endmodule
bind bdf_top bdf_asserts bdf_asserts_i (.sys_clk(sys_clk), .rst(rst),
	.port_a_clock(port_a_clock), .port_b_clock(port_b_clock),
	.port_a_select_n(port_a_select_n), .port_a_write(port_a_write),
	.port_a_mail_select(port_a_mail_select), .port_a_data_oe_n(port_a_data_oe_n),
	.port_a_full_n(port_a_full_n), .port_b_full_n(port_b_full_n),
	.port_a_empty_n(port_a_empty_n), .port_b_empty_n(port_b_empty_n),
	.port_a_almost_empty_n(port_a_almost_empty_n),
	.port_b_almost_empty_n(port_b_almost_empty_n), .mail_to_b_flag_n(mail_to_b_flag_n));
`default_nettype wire

// *** sim/bdf_port_model.sv ***
// host master driving one port's pins on a free-running port clock
`timescale 1ns/1ps
`default_nettype none
module bdf_port_model
	import bdf_pkg::*;
#(
	parameter int HALF = 5
) (
	// system
	input  wire logic              sys_clk,
	// port pins
	output logic                   clock,
	output logic                   select_n,
	output logic                   enable,
	output logic                   write,
	output logic                   mail_select,
	output logic                   parity_gen,
	output logic      [DATA_W-1:0] data_in,
	input  wire logic [DATA_W-1:0] data_out,
	input  wire logic              data_oe_n
);
	int cnt = 0;
	// idle pins at start
	initial begin
		clock = 1'b0;
		select_n = 1'b1;
		enable = 1'b0;
		write = 1'b0;
		mail_select = 1'b0;
		parity_gen = 1'b0;
		data_in = 36'h0;
	end
	// port clock, whole system cycles per phase
	always @(posedge sys_clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) clock <= ~clock;
	end
	// one transfer held across one rising port edge
	task automatic xfer(input logic w, m, g, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q, output logic oe);
		@(negedge clock);
		@(posedge sys_clk);
		select_n <= 1'b0;
		enable <= 1'b1;
		write <= w;
		mail_select <= m;
		parity_gen <= g;
		data_in <= d;
		@(posedge clock);
		repeat (5) @(posedge sys_clk);
		q = data_out;
		oe = data_oe_n;
		@(negedge clock);
		@(posedge sys_clk);
		select_n <= 1'b1;
		enable <= 1'b0;
		data_in <= ~d; // released bus no longer shows the word
	endtask
endmodule
`default_nettype wire

// *** sim/tb_bidirectional_dual_clock_fifo.sv ***
// self-checking bench for the bidirectional buffer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_bidirectional_dual_clock_fifo;
	import bdf_pkg::*;
	logic              sys_clk, rst, ce, odd, s_lo, s_hi, mf_b_n, mf_a_n;
	logic              a_clk, a_cs_n, a_en, a_wr, a_mb, a_pg, a_oe_n, a_pe_n;
	logic              b_clk, b_cs_n, b_en, b_wr, b_mb, b_pg, b_oe_n, b_pe_n;
	logic              a_full_n, a_empty_n, a_af_n, a_ae_n;
	logic              b_full_n, b_empty_n, b_af_n, b_ae_n;
	logic [DATA_W-1:0] a_din, a_dout, b_din, b_dout;
	wire  [DATA_W-1:0] a_bus, b_bus;
	logic [DATA_W-1:0] sb[2][$];
	int                errors = 0, checked = 0, cycles = 0, x;
	// bus level from both drivers
	assign a_bus = a_oe_n ? a_din : a_dout;
	assign b_bus = b_oe_n ? b_din : b_dout;
	bdf_top bdf_top_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.port_a_clock(a_clk), .port_a_select_n(a_cs_n), .port_a_enable(a_en),
		.port_a_write(a_wr), .port_a_mail_select(a_mb), .port_a_parity_gen(a_pg),
		.port_a_data_in(a_bus), .port_a_data_out(a_dout), .port_a_data_oe_n(a_oe_n),
		.port_a_full_n(a_full_n), .port_a_empty_n(a_empty_n), .port_a_almost_full_n(a_af_n),
		.port_a_almost_empty_n(a_ae_n), .port_a_parity_error_n(a_pe_n),
		.port_b_clock(b_clk), .port_b_select_n(b_cs_n), .port_b_enable(b_en),
		.port_b_write(b_wr), .port_b_mail_select(b_mb), .port_b_parity_gen(b_pg),
		.port_b_data_in(b_bus), .port_b_data_out(b_dout), .port_b_data_oe_n(b_oe_n),
		.port_b_full_n(b_full_n), .port_b_empty_n(b_empty_n), .port_b_almost_full_n(b_af_n),
		.port_b_almost_empty_n(b_ae_n), .port_b_parity_error_n(b_pe_n),
		.mail_to_b_flag_n(mf_b_n), .mail_to_a_flag_n(mf_a_n), .parity_odd(odd),
		.offset_select_low(s_lo), .offset_select_high(s_hi));
	bdf_port_model #(.HALF(5)) pa (.sys_clk(sys_clk), .clock(a_clk), .select_n(a_cs_n),
		.enable(a_en), .write(a_wr), .mail_select(a_mb), .parity_gen(a_pg),
		.data_in(a_din), .data_out(a_dout), .data_oe_n(a_oe_n));
	bdf_port_model #(.HALF(6)) pb (.sys_clk(sys_clk), .clock(b_clk), .select_n(b_cs_n),
		.enable(b_en), .write(b_wr), .mail_select(b_mb), .parity_gen(b_pg),
		.data_in(b_din), .data_out(b_dout), .data_oe_n(b_oe_n));
	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// flags of one port: full, almost full, empty, almost empty
	function automatic logic [3:0] fl(input int p);
		return p ? {b_full_n, b_af_n, b_empty_n, b_ae_n} : {a_full_n, a_af_n, a_empty_n, a_ae_n};
	endfunction
	// regenerated byte parity
	function automatic logic [DATA_W-1:0] par(input logic [DATA_W-1:0] d, input logic o);
		for (int i = 0; i < BYTES; i++)
			d[BYTE_W*i+8] = ^d[BYTE_W*i+:8] ^ o;
		return d;
	endfunction
	task automatic xf(input int p, input logic w, m, g, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q, output logic oe);
		if (p) pb.xfer(w, m, g, d, q, oe);
		else pa.xfer(w, m, g, d, q, oe);
	endtask
	// write one past full from port p
	task automatic fill(input int p);
		logic [DATA_W-1:0] d, q;
		logic [3:0]        f;
		logic              oe;
		for (int k = 1; k <= DEPTH + 1; k++) begin
			d = DATA_W'({$urandom, $urandom});
			if (k <= DEPTH) sb[p].push_back(d);
			xf(p, 1'b1, 1'b0, 1'b0, d, q, oe);
			f = fl(p);
			`CHK(oe, 1'b1)
			`CHK(f[3], k < DEPTH)
			`CHK(f[2], DEPTH - k > x)
		end
	endtask
	// read the queue filled from port p, once past empty
	task automatic drain(input int p);
		logic [DATA_W-1:0] e, q;
		logic [3:0]        f;
		logic              oe;
		`CHK(fl(1 - p), 4'h3)
		for (int k = 0; k <= DEPTH; k++) begin
			xf(1 - p, 1'b0, 1'b0, 1'b0, 36'h0, q, oe);
			f = fl(1 - p);
			`CHK(oe, 1'b0)
			if (k < DEPTH) begin
				e = sb[p].pop_front();
				`CHK(q, e)
			end
			`CHK(f[1], k < DEPTH - 1)
			`CHK(f[0], DEPTH - 1 - k > x)
		end
	endtask
	// mail each way, second write refused, optional parity regeneration
	task automatic mail(input int s);
		logic [DATA_W-1:0] d, q;
		logic              oe;
		for (int p = 0; p < 2; p++) begin
			d = DATA_W'({$urandom, $urandom});
			xf(p, 1'b1, 1'b1, 1'b0, d, q, oe);
			`CHK(p ? mf_a_n : mf_b_n, 1'b0)
			`CHK(p ? b_pe_n : a_pe_n, par(d, s[1]) === d)
			xf(p, 1'b1, 1'b1, 1'b0, ~d, q, oe);
			xf(1 - p, 1'b0, 1'b1, s[0], 36'h0, q, oe);
			`CHK(q, s[0] ? par(d, s[1]) : d)
			`CHK(p ? mf_a_n : mf_b_n, 1'b1)
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			tally_and_finish();
		end
	end
	// every offset preset in turn, reset between
	initial begin
		ce <= 1'b1;
		void'($urandom(54));
		for (int s = 0; s < 4; s++) begin
			{s_hi, s_lo} <= 2'(s);
			odd <= s[1];
			rst <= 1'b1;
			x = s[1] ? (s[0] ? OFFSET_3 : OFFSET_2) : (s[0] ? OFFSET_1 : OFFSET_0);
			repeat (5) @(posedge sys_clk);
			rst <= 1'b0;
			repeat (40) @(posedge sys_clk);
			`CHK({fl(0), fl(1), mf_a_n, mf_b_n}, 10'h333)
			fork
				fill(0);
				fill(1);
			join
			repeat (40) @(posedge sys_clk);
			fork
				drain(0);
				drain(1);
			join
			mail(s);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** src/bdf_mem.sv ***
// one queue's storage, registered read
`timescale 1ns/1ps
`default_nettype none
module bdf_mem
	import bdf_pkg::*;
(
	// clock
	input  wire logic              sys_clk,
	input  wire logic              ce,
	// write side
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	// read side
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] store [DEPTH];

	// write and read on the same edge without conflict
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			if (wr_en) begin
				store[wr_addr] <= wr_data;
			end
			rd_data <= store[rd_addr];
		end
	end
endmodule
`default_nettype wire

// *** src/bdf_pkg.sv ***
// constants shared by the bidirectional dual-queue buffer
// Functional notes
// - two 64-word by 36-bit queues, one per direction
// - each port has its own clock; reads and writes may share one edge
// - transfers happen only on a qualified rising edge of the port clock
// - full and almost-full pass two stages on the writer's clock
// - empty and almost-empty pass two stages on the reader's clock
// - port A almost-empty low when B-to-A count is at most X
// - port B almost-empty low when A-to-B count is at most X
// - port A almost-full low when A-to-B free space is at most X
// - port B almost-full low when B-to-A free space is at most X
// - chip select must be low for any port transfer
// - data outputs float while chip select is high
// - port A empty low blocks reads of B-to-A queue
// - port B empty low blocks reads of A-to-B queue
// - empty low at reset; rises on second reader edge after a word
// - each port has one 36-bit two-way data bus
// - two 36-bit mailbox registers bypass the queues
// - each mailbox has a flag marking uncollected new mail
// - incoming byte parity is checked passively, never blocking
// - parity bits on read data optionally regenerated, per port
// - port enable must be high for any port transfer
// - offset selects latched at reset release choose one of four X
// - full low during reset, high by second writer edge afterwards
// - mailbox write lowers flag and blocks writes; mail read or reset raise it
package bdf_pkg;
	localparam int DATA_W = 36;
	localparam int ADDR_W = 6;
	localparam int PTR_W = 7;
	localparam int DEPTH = 64;
	localparam logic [6:0] DEPTH_CNT = 7'h40;
	localparam int BYTES = 4;
	localparam int BYTE_W = 9;
	// preset offsets picked by the two offset selects
	localparam logic [6:0] OFFSET_0 = 7'h10;
	localparam logic [6:0] OFFSET_1 = 7'h0c;
	localparam logic [6:0] OFFSET_2 = 7'h08;
	localparam logic [6:0] OFFSET_3 = 7'h04;
	// layout of a port's pin bundle
	localparam int PIN_W = 42;
	localparam int PIN_CLK = 41;
	localparam int PIN_SEL_N = 40;
	localparam int PIN_EN = 39;
	localparam int PIN_WR = 38;
	localparam int PIN_MB = 37;
	localparam int PIN_PG = 36;
	// pin bundle value held in reset: clock high, select high, rest low
	localparam logic [PIN_W-1:0] PIN_IDLE = 42'h30000000000;
	// write-side buffer
	localparam logic [1:0] BUF_FULL = 2'h2;
	// strap capture point after reset release
	localparam logic [1:0] BOOT_CAPTURE = 2'h2;
	localparam logic [1:0] BOOT_DONE = 2'h3;
	localparam logic [PTR_W-1:0] PTR_ZERO = 7'h00;
	localparam logic [PTR_W-1:0] PTR_ONE = 7'h01;
	localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
endpackage

// *** src/bdf_top.sv ***
// bidirectional dual-queue buffer with mailboxes and parity
`timescale 1ns/1ps
`default_nettype none
module bdf_top
	import bdf_pkg::*;
(
	// system
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// port a pins
	input  wire logic              port_a_clock,
	input  wire logic              port_a_select_n,
	input  wire logic              port_a_enable,
	input  wire logic              port_a_write,
	input  wire logic              port_a_mail_select,
	input  wire logic              port_a_parity_gen,
	input  wire logic [DATA_W-1:0] port_a_data_in,
	output logic      [DATA_W-1:0] port_a_data_out,
	output logic                   port_a_data_oe_n,
	// port a flags
	output logic                   port_a_full_n,
	output logic                   port_a_empty_n,
	output logic                   port_a_almost_full_n,
	output logic                   port_a_almost_empty_n,
	output logic                   port_a_parity_error_n,
	// port b pins
	input  wire logic              port_b_clock,
	input  wire logic              port_b_select_n,
	input  wire logic              port_b_enable,
	input  wire logic              port_b_write,
	input  wire logic              port_b_mail_select,
	input  wire logic              port_b_parity_gen,
	input  wire logic [DATA_W-1:0] port_b_data_in,
	output logic      [DATA_W-1:0] port_b_data_out,
	output logic                   port_b_data_oe_n,
	// port b flags
	output logic                   port_b_full_n,
	output logic                   port_b_empty_n,
	output logic                   port_b_almost_full_n,
	output logic                   port_b_almost_empty_n,
	output logic                   port_b_parity_error_n,
	// mailbox flags
	output logic                   mail_to_b_flag_n,
	output logic                   mail_to_a_flag_n,
	// shared configuration pins
	input  wire logic              parity_odd,
	input  wire logic              offset_select_low,
	input  wire logic              offset_select_high
);
	// byte parity failure of a 36-bit word
	function automatic logic parity_fail(input logic [DATA_W-1:0] d, input logic odd);
		logic f;
		f = 1'b0;
		for (int i = 0; i < BYTES; i++) begin
			f = f | ((^d[i*BYTE_W +: BYTE_W]) != odd);
		end
		return f;
	endfunction

	// replace each byte's top bit with generated parity
	function automatic logic [DATA_W-1:0] parity_fill(input logic [DATA_W-1:0] d,
		input logic odd);
		logic [DATA_W-1:0] r;
		r = d;
		for (int i = 0; i < BYTES; i++) begin
			r[i*BYTE_W + BYTE_W - 1] = (^d[i*BYTE_W +: BYTE_W-1]) ^ odd;
		end
		return r;
	endfunction

	// per-port pin bundles, index 0 is port a, 1 is port b
	logic [PIN_W-1:0]  pin_raw [2];
	logic [PIN_W-1:0]  pin_s1 [2];
	logic [PIN_W-1:0]  pin_s2 [2];
	logic              clk_prev [2];
	logic              edge_ev [2];
	logic              xfer [2];
	logic              wr_ev [2];
	logic              rd_ev [2];
	logic              mwr_ev [2];
	logic              mrd_ev [2];
	logic [DATA_W-1:0] dout [2];
	logic              oe_n [2];
	logic              perr_n [2];

	// per-queue state, queue q is written by port q and read by port 1-q
	logic [DATA_W-1:0] buf0 [2];
	logic [DATA_W-1:0] buf1 [2];
	logic [1:0]        buf_cnt [2];
	logic              push [2];
	logic              pop [2];
	logic [PTR_W-1:0]  wr_acc [2];
	logic [PTR_W-1:0]  wr_ptr [2];
	logic [PTR_W-1:0]  rd_ptr [2];
	logic [PTR_W-1:0]  rd_copy [2];
	logic [PTR_W-1:0]  wr_copy [2];
	logic              started [2];
	logic              full_n [2];
	logic              afull_n [2];
	logic              empty_n [2];
	logic              aempty_n [2];
	logic [DATA_W-1:0] mem_q [2];
	logic [DATA_W-1:0] qout [2];
	logic [DATA_W-1:0] mail [2];
	logic              mflag_n [2];
	logic              in_ready [2];
	logic              out_valid [2];
	logic              out_ready [2];

	// offset strap and parity sense
	logic              odd_s1;
	logic              odd_s2;
	logic [1:0]        cfg_s1;
	logic [1:0]        cfg_s2;
	logic [1:0]        boot_cnt;
	logic [PTR_W-1:0]  offset_x;

	assign pin_raw[0] = {port_a_clock, port_a_select_n, port_a_enable, port_a_write,
		port_a_mail_select, port_a_parity_gen, port_a_data_in};
	assign pin_raw[1] = {port_b_clock, port_b_select_n, port_b_enable, port_b_write,
		port_b_mail_select, port_b_parity_gen, port_b_data_in};

	// offset selects and parity sense synchronized; offsets caught once after reset release
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			odd_s1 <= 1'b0;
			odd_s2 <= 1'b0;
			cfg_s1 <= 2'h0;
			cfg_s2 <= 2'h0;
			boot_cnt <= 2'h0;
			offset_x <= OFFSET_0;
		end else if (ce) begin
			odd_s1 <= parity_odd;
			odd_s2 <= odd_s1;
			cfg_s1 <= {offset_select_high, offset_select_low};
			cfg_s2 <= cfg_s1;
			if (boot_cnt != BOOT_DONE) begin
				boot_cnt <= boot_cnt + 2'h1;
			end
			if (boot_cnt == BOOT_CAPTURE) begin
				unique case (cfg_s2)
					2'h0: offset_x <= OFFSET_0;
					2'h1: offset_x <= OFFSET_1;
					2'h2: offset_x <= OFFSET_2;
					2'h3: offset_x <= OFFSET_3;
				endcase
			end
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_port
		// two flops on every pin before use
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				// idle as clock high and deselected: no false edge or bus drive after reset
				pin_s1[p] <= PIN_IDLE;
				pin_s2[p] <= PIN_IDLE;
				clk_prev[p] <= 1'b1;
			end else if (ce) begin
				pin_s1[p] <= pin_raw[p];
				pin_s2[p] <= pin_s1[p];
				clk_prev[p] <= pin_s2[p][PIN_CLK];
			end
		end

		// qualified port clock edge and its transfer kinds
		assign edge_ev[p] = pin_s2[p][PIN_CLK] & ~clk_prev[p];
		assign xfer[p] = edge_ev[p] & ~pin_s2[p][PIN_SEL_N] & pin_s2[p][PIN_EN];
		assign wr_ev[p] = xfer[p] & pin_s2[p][PIN_WR] & ~pin_s2[p][PIN_MB];
		assign rd_ev[p] = xfer[p] & ~pin_s2[p][PIN_WR] & ~pin_s2[p][PIN_MB];
		assign mwr_ev[p] = xfer[p] & pin_s2[p][PIN_WR] & pin_s2[p][PIN_MB];
		assign mrd_ev[p] = xfer[p] & ~pin_s2[p][PIN_WR] & pin_s2[p][PIN_MB];

		// read data: mailbox or queue output register, parity optionally rebuilt
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				dout[p] <= DATA_ZERO;
			end else if (ce) begin
				if (pin_s2[p][PIN_PG]) begin
					dout[p] <= parity_fill(pin_s2[p][PIN_MB] ? mail[1-p] : qout[1-p],
						odd_s2);
				end else begin
					dout[p] <= pin_s2[p][PIN_MB] ? mail[1-p] : qout[1-p];
				end
			end
		end

		// bus drive only when selected and reading
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				oe_n[p] <= 1'b1;
			end else if (ce) begin
				oe_n[p] <= pin_s2[p][PIN_SEL_N] | pin_s2[p][PIN_WR];
			end
		end

		// passive parity check of applied write data
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				perr_n[p] <= 1'b1;
			end else if (ce) begin
				perr_n[p] <= ~(~pin_s2[p][PIN_SEL_N] & pin_s2[p][PIN_WR]
					& parity_fail(pin_s2[p][DATA_W-1:0], odd_s2));
			end
		end
	end

	for (genvar q = 0; q < 2; q++) begin : g_queue
		// buffer handshake: takes writes while a slot is free, feeds memory while it has room
		assign in_ready[q] = (buf_cnt[q] != BUF_FULL);
		assign out_valid[q] = (buf_cnt[q] != 2'h0);
		assign out_ready[q] = (PTR_W'(wr_ptr[q] - rd_ptr[q]) != DEPTH_CNT);
		// write accepted only with room in queue and buffer
		assign push[q] = wr_ev[q] & full_n[q] & in_ready[q];
		// buffer drains while memory has room
		assign pop[q] = out_valid[q] & out_ready[q];

		// two-entry write buffer ahead of the memory
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				buf0[q] <= DATA_ZERO;
				buf1[q] <= DATA_ZERO;
				buf_cnt[q] <= 2'h0;
			end else if (ce) begin
				if (push[q] && pop[q]) begin
					if (buf_cnt[q] == 2'h1) begin
						buf0[q] <= pin_s2[q][DATA_W-1:0];
					end else begin
						buf0[q] <= buf1[q];
						buf1[q] <= pin_s2[q][DATA_W-1:0];
					end
				end else if (pop[q]) begin
					buf0[q] <= buf1[q];
					buf_cnt[q] <= buf_cnt[q] - 2'h1;
				end else if (push[q]) begin
					if (buf_cnt[q] == 2'h0) begin
						buf0[q] <= pin_s2[q][DATA_W-1:0];
					end else begin
						buf1[q] <= pin_s2[q][DATA_W-1:0];
					end
					buf_cnt[q] <= buf_cnt[q] + 2'h1;
				end
			end
		end

		bdf_mem u_mem (
			.sys_clk (sys_clk),
			.ce      (ce),
			.wr_en   (pop[q]),
			.wr_addr (wr_ptr[q][ADDR_W-1:0]),
			.wr_data (buf0[q]),
			.rd_addr (rd_ptr[q][ADDR_W-1:0]),
			.rd_data (mem_q[q])
		);

		// writer side: accepted count, copied read pointer, full flags
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				wr_acc[q] <= PTR_ZERO;
				wr_ptr[q] <= PTR_ZERO;
				rd_copy[q] <= PTR_ZERO;
				started[q] <= 1'b0;
				full_n[q] <= 1'b0;
				afull_n[q] <= 1'b0;
			end else if (ce) begin
				if (pop[q]) begin
					wr_ptr[q] <= wr_ptr[q] + PTR_ONE;
				end
				if (edge_ev[q]) begin
					wr_acc[q] <= wr_acc[q] + (push[q] ? PTR_ONE : PTR_ZERO);
					rd_copy[q] <= rd_ptr[q];
					started[q] <= 1'b1;
					full_n[q] <= started[q] & (PTR_W'(wr_acc[q]
						+ (push[q] ? PTR_ONE : PTR_ZERO) - rd_copy[q]) != DEPTH_CNT);
					afull_n[q] <= started[q] & (PTR_W'(DEPTH_CNT - PTR_W'(wr_acc[q]
						+ (push[q] ? PTR_ONE : PTR_ZERO) - rd_copy[q])) > offset_x);
				end
			end
		end

		// reader side: read pointer, copied write pointer, empty flags
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				rd_ptr[q] <= PTR_ZERO;
				wr_copy[q] <= PTR_ZERO;
				empty_n[q] <= 1'b0;
				aempty_n[q] <= 1'b0;
				qout[q] <= DATA_ZERO;
			end else if (ce && edge_ev[1-q]) begin
				wr_copy[q] <= wr_ptr[q];
				if (rd_ev[1-q] && empty_n[q]) begin
					rd_ptr[q] <= rd_ptr[q] + PTR_ONE;
					qout[q] <= mem_q[q];
					empty_n[q] <= (wr_copy[q] != PTR_W'(rd_ptr[q] + PTR_ONE));
					aempty_n[q] <= (PTR_W'(wr_copy[q] - rd_ptr[q] - PTR_ONE)
						> offset_x);
				end else begin
					empty_n[q] <= (wr_copy[q] != rd_ptr[q]);
					aempty_n[q] <= (PTR_W'(wr_copy[q] - rd_ptr[q]) > offset_x);
				end
			end
		end

		// mailbox written by port q, collected by the other port
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				mail[q] <= DATA_ZERO;
				mflag_n[q] <= 1'b1;
			end else if (ce) begin
				if (mwr_ev[q] && mflag_n[q]) begin
					mail[q] <= pin_s2[q][DATA_W-1:0];
					mflag_n[q] <= 1'b0;
				end else if (mrd_ev[1-q]) begin
					mflag_n[q] <= 1'b1;
				end
			end
		end
	end

	// output mapping, each from a flop
	assign port_a_data_out = dout[0];
	assign port_a_data_oe_n = oe_n[0];
	assign port_a_parity_error_n = perr_n[0];
	assign port_a_full_n = full_n[0];
	assign port_a_almost_full_n = afull_n[0];
	assign port_a_empty_n = empty_n[1];
	assign port_a_almost_empty_n = aempty_n[1];

	// port b outputs
	assign port_b_data_out = dout[1];
	assign port_b_data_oe_n = oe_n[1];
	assign port_b_parity_error_n = perr_n[1];
	assign port_b_full_n = full_n[1];
	assign port_b_almost_full_n = afull_n[1];
	assign port_b_empty_n = empty_n[0];
	assign port_b_almost_empty_n = aempty_n[0];

	// mailbox flags
	assign mail_to_b_flag_n = mflag_n[0];
	assign mail_to_a_flag_n = mflag_n[1];
endmodule
`default_nettype wire
